/* File: hdl/can_bit_timing_defs.svh */
`ifndef CAN_BIT_TIMING_DEFS_SVH
`define CAN_BIT_TIMING_DEFS_SVH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define CBT_OFS_TIMING      12'h000
`define CBT_OFS_CONTROL     12'h004
`define CBT_OFS_STATUS      12'h008

// ****************************************************************
// Bit timing register fields
// ****************************************************************
`define CBT_PRESC_LSB       0
`define CBT_PRESC_MSB       5
`define CBT_JUMP_LSB        6
`define CBT_JUMP_MSB        7
`define CBT_PROP_LSB        8
`define CBT_PROP_MSB        10
`define CBT_PH1_LSB         11
`define CBT_PH1_MSB         13
`define CBT_PH2_FREE_BIT    14
`define CBT_TRIPLE_BIT      15
`define CBT_PH2_LSB         16
`define CBT_PH2_MSB         18
`define CBT_TIMING_MASK     32'h0007FFFF
`define CBT_TIMING_RESET    32'h00000000

// ****************************************************************
// Module control register fields
// ****************************************************************
`define CBT_OPMODE_LSB      21
`define CBT_OPMODE_MSB      23
`define CBT_OPMODE_CONFIG   3'h4
`define CBT_OPMODE_RESET    3'h4

// ****************************************************************
// Status register fields
// ****************************************************************
`define CBT_STAT_QPB_LSB    0
`define CBT_STAT_QPB_MSB    4
`define CBT_STAT_JUMP_ERR   8
`define CBT_STAT_PH2_ERR    9
`define CBT_STAT_TRIPLE_ERR 10
`define CBT_STAT_QPB_ERR    11
`define CBT_STAT_CONFIG     12

// ****************************************************************
// Timing limits
// ****************************************************************
`define CBT_QPB_MIN_EXCL    5'h07
`define CBT_TRIPLE_PRESC_MIN 6'h02

`endif

/* File: hdl/can_bit_timing_pkg.sv */
package can_bit_timing_pkg;

  // One-hot states of the bit segment sequencer
  typedef enum logic [4:0] {
    SEQ_IDLE  = 5'h01,
    SEQ_SYNC  = 5'h02,
    SEQ_PROP  = 5'h04,
    SEQ_PHONE = 5'h08,
    SEQ_PHTWO = 5'h10
  } seq_state_t;

endpackage

/* File: hdl/quantum_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Time quantum tick generator
// ****************************************************************
module quantum_prescaler (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_run,
  input  wire logic [5:0] i_presc,
  output logic            o_tq_tick
);

  logic [6:0] cnt_q;
  logic [6:0] last_cyc;

  // One quantum spans 2 x (field + 1) clocks, so the last count is {field, 1}
  assign last_cyc = {i_presc, 1'b1};

  // Counter restarts while stopped so the first quantum is always whole
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_run) begin
      cnt_q <= 7'h00;
    end else if (cnt_q >= last_cyc) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // Tick on the final clock of each quantum
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_run) begin
      o_tq_tick <= 1'b0;
    end else begin
      o_tq_tick <= (cnt_q >= last_cyc);
    end
  end

endmodule

`default_nettype wire

/* File: hdl/can_bit_timing_config.sv */
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

`include "can_bit_timing_defs.svh"

// Overview of operation
// - propagation segment is field plus one quanta
// - jump width is field plus one quanta
// - quantum is two times (prescaler plus one) clocks
// - phase two derived unless free select set
// - timing writable only in configuration mode
module can_bit_timing_config (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_tq_tick,
  output logic             o_bit_start,
  output logic             o_sample_point,
  output logic             o_triple_sample,
  output logic [3:0]       o_prop_quanta,
  output logic [2:0]       o_jump_quanta,
  output logic [3:0]       o_phase_one_quanta,
  output logic [3:0]       o_phase_two_quanta,
  output logic [4:0]       o_quanta_per_bit
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Field value plus one, as a quanta count
  function automatic logic [3:0] quanta_len(input logic [2:0] fld);
    quanta_len = {1'b0, fld} + 4'h1;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0] timing_q;
  logic [2:0]  opmode_q;
  logic        in_config;
  logic        apb_done;
  logic        addr_timing;
  logic        addr_control;
  logic        addr_status;
  logic        addr_hit;

  assign in_config    = (opmode_q == `CBT_OPMODE_CONFIG);
  assign addr_timing  = (i_paddr == `CBT_OFS_TIMING);
  assign addr_control = (i_paddr == `CBT_OFS_CONTROL);
  assign addr_status  = (i_paddr == `CBT_OFS_STATUS);
  assign addr_hit     = addr_timing | addr_control | addr_status;

  // A transfer completes on the edge where the registered ready is seen
  assign apb_done = i_psel & i_penable & o_pready;

  // ****************************************************************
  // Decoded timing fields
  // ****************************************************************
  logic [5:0] presc;
  logic [3:0] prop_len;
  logic [2:0] jump_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;
  logic       ph2_free;
  logic       triple;
  logic [4:0] qpb;

  assign presc    = timing_q[`CBT_PRESC_MSB:`CBT_PRESC_LSB];
  assign prop_len = quanta_len(timing_q[`CBT_PROP_MSB:`CBT_PROP_LSB]);
  assign jump_len = timing_q[`CBT_JUMP_MSB:`CBT_JUMP_LSB] + 3'h1;
  assign ph1_len  = quanta_len(timing_q[`CBT_PH1_MSB:`CBT_PH1_LSB]);
  assign ph2_free = timing_q[`CBT_PH2_FREE_BIT];
  assign triple   = timing_q[`CBT_TRIPLE_BIT];

  // Without free select, phase two follows phase one, which always meets its limit
  assign ph2_len  = ph2_free ? quanta_len(timing_q[`CBT_PH2_MSB:`CBT_PH2_LSB])
                             : ph1_len;

  // Sync quantum plus the three segments
  assign qpb = 5'h01 + {1'b0, prop_len} + {1'b0, ph1_len} + {1'b0, ph2_len};

  // ****************************************************************
  // Setting checks reported to software
  // ****************************************************************
  logic jump_err;
  logic ph2_err;
  logic triple_err;
  logic qpb_err;

  // These are software duties; the block flags a breach, and triple_err also holds off triple sampling
  assign jump_err   = ({1'b0, jump_len} > ph2_len);
  assign ph2_err    = ph2_free & (ph2_len > ph1_len);
  assign triple_err = triple & (presc < `CBT_TRIPLE_PRESC_MIN);
  assign qpb_err    = (qpb <= `CBT_QPB_MIN_EXCL);

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // One wait state: ready rises in the second access cycle, falls after completion
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
    end
  end

  // Unmapped addresses answer with an error alongside ready
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= i_psel & i_penable & ~o_pready & ~addr_hit;
    end
  end

  // Read data captured with ready, held until the next read access
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
      o_prdata <= 32'h00000000;
      if (addr_timing) begin
        o_prdata <= timing_q;
      end else if (addr_control) begin
        o_prdata[`CBT_OPMODE_MSB:`CBT_OPMODE_LSB] <= opmode_q;
      end else if (addr_status) begin
        o_prdata[`CBT_STAT_QPB_MSB:`CBT_STAT_QPB_LSB] <= qpb;
        o_prdata[`CBT_STAT_JUMP_ERR]                  <= jump_err;
        o_prdata[`CBT_STAT_PH2_ERR]                   <= ph2_err;
        o_prdata[`CBT_STAT_TRIPLE_ERR]                <= triple_err;
        o_prdata[`CBT_STAT_QPB_ERR]                   <= qpb_err;
        o_prdata[`CBT_STAT_CONFIG]                    <= in_config;
      end
    end
  end

  // Operating mode: always writable, so software can enter configuration mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      opmode_q <= `CBT_OPMODE_RESET;
    end else if (apb_done & i_pwrite & addr_control) begin
      opmode_q <= i_pwdata[`CBT_OPMODE_MSB:`CBT_OPMODE_LSB];
    end
  end

  // Timing only changes in configuration mode; other writes are dropped silently
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      timing_q <= `CBT_TIMING_RESET;
    end else if (apb_done & i_pwrite & addr_timing & in_config) begin
      timing_q <= i_pwdata & `CBT_TIMING_MASK;
    end
  end

  // ****************************************************************
  // Quantum generation
  // ****************************************************************
  logic tq_tick;

  // Bit timing runs only outside configuration mode, so settings never change mid-bit
  quantum_prescaler u_presc (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_run     (~in_config),
    .i_presc   (presc),
    .o_tq_tick (tq_tick)
  );

  // ****************************************************************
  // Bit segment sequencer
  // ****************************************************************
  can_bit_timing_pkg::seq_state_t state_q;
  can_bit_timing_pkg::seq_state_t state_d;
  logic [3:0]                     seg_cnt_q;
  logic [3:0]                     seg_last;
  logic                           seg_end;

  // Last quantum index of the segment being timed
  always_comb begin
    case (state_q)
      can_bit_timing_pkg::SEQ_PROP:  seg_last = prop_len - 4'h1;
      can_bit_timing_pkg::SEQ_PHONE: seg_last = ph1_len - 4'h1;
      can_bit_timing_pkg::SEQ_PHTWO: seg_last = ph2_len - 4'h1;
      default:                       seg_last = 4'h0;
    endcase
  end

  assign seg_end = tq_tick & (seg_cnt_q == seg_last);

  // Next segment on the last quantum of the current one
  always_comb begin
    state_d = state_q;
    case (state_q)
      can_bit_timing_pkg::SEQ_IDLE: begin
        if (!in_config) begin
          state_d = can_bit_timing_pkg::SEQ_SYNC;
        end
      end
      can_bit_timing_pkg::SEQ_SYNC: begin
        if (tq_tick) begin
          state_d = can_bit_timing_pkg::SEQ_PROP;
        end
      end
      can_bit_timing_pkg::SEQ_PROP: begin
        if (seg_end) begin
          state_d = can_bit_timing_pkg::SEQ_PHONE;
        end
      end
      can_bit_timing_pkg::SEQ_PHONE: begin
        if (seg_end) begin
          state_d = can_bit_timing_pkg::SEQ_PHTWO;
        end
      end
      can_bit_timing_pkg::SEQ_PHTWO: begin
        if (seg_end) begin
          state_d = can_bit_timing_pkg::SEQ_SYNC;
        end
      end
      default: begin
        state_d = can_bit_timing_pkg::SEQ_IDLE;
      end
    endcase
    if (in_config) begin
      state_d = can_bit_timing_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_q <= can_bit_timing_pkg::SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Quantum count within the current segment
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || in_config) begin
      seg_cnt_q <= 4'h0;
    end else if (state_d != state_q) begin
      seg_cnt_q <= 4'h0;
    end else if (tq_tick) begin
      seg_cnt_q <= seg_cnt_q + 4'h1;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Bit start marks entry to the sync quantum, sample point the end of phase one
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_tq_tick      <= 1'b0;
      o_bit_start    <= 1'b0;
      o_sample_point <= 1'b0;
    end else begin
      o_tq_tick      <= tq_tick & ~in_config; // A tick still in flight is dropped at config entry
      o_bit_start    <= (state_d == can_bit_timing_pkg::SEQ_SYNC) &&
                        (state_q != can_bit_timing_pkg::SEQ_SYNC);
      o_sample_point <= (state_q == can_bit_timing_pkg::SEQ_PHONE) && seg_end;
    end
  end

  // Decoded lengths for the bit engine; triple sampling held off when illegal
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_triple_sample    <= 1'b0;
      o_prop_quanta      <= 4'h1;
      o_jump_quanta      <= 3'h1;
      o_phase_one_quanta <= 4'h1;
      o_phase_two_quanta <= 4'h1;
      o_quanta_per_bit   <= 5'h04;
    end else begin
      o_triple_sample    <= triple & ~triple_err;
      o_prop_quanta      <= prop_len;
      o_jump_quanta      <= jump_len;
      o_phase_one_quanta <= ph1_len;
      o_phase_two_quanta <= ph2_len;
      o_quanta_per_bit   <= qpb;
    end
  end

endmodule

`default_nettype wire

/* File: verif/can_bit_timing_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Bit timing checker
// ****
module can_bit_timing_monitor (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_tq_tick,
  input wire logic        o_triple_sample,
  input wire logic [3:0]  o_prop_quanta,
  input wire logic [2:0]  o_jump_quanta,
  input wire logic [3:0]  o_phase_one_quanta,
  input wire logic [3:0]  o_phase_two_quanta
);
  logic [2:0] mode_q;
  logic [5:0] presc_q;
  logic [7:0] gap_q;
  logic       seen_q;
  logic       wr_done;
  logic       twr;
  logic       cfg;
  // Completed writes decoded from the bus
  assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
  assign twr     = wr_done && (i_paddr == 12'h000);
  assign cfg     = (mode_q == 3'h4);
  // Shadow of mode and prescaler, so checks need no internal probes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mode_q  <= 3'h4;
      presc_q <= 6'h00;
    end else if (wr_done && i_paddr == 12'h004) begin
      mode_q <= i_pwdata[23:21];
    end else if (twr && cfg) begin
      presc_q <= i_pwdata[5:0];
    end
  end
  // Cycles since last tick; first gap after config exit is not judged
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || cfg) begin
      gap_q  <= 8'h01;
      seen_q <= 1'b0;
    end else if (o_tq_tick) begin
      gap_q  <= 8'h01;
      seen_q <= 1'b1;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_cfg_write;
    twr && cfg;
  endsequence
  sequence s_access;
    i_psel && i_penable && !$past(i_penable);
  endsequence
  chk_prop_len: assert property (s_cfg_write |-> ##2
    o_prop_quanta == {1'b0, $past(i_pwdata[10:8], 2)} + 4'h1) else $error("prop length");
  chk_jump_len: assert property (s_cfg_write |-> ##2
    o_jump_quanta == {1'b0, $past(i_pwdata[7:6], 2)} + 3'h1) else $error("jump width");
  chk_phase_two: assert property (s_cfg_write |-> ##2 o_phase_two_quanta ==
    ($past(i_pwdata[14], 2) ? {1'b0, $past(i_pwdata[18:16], 2)}
     : {1'b0, $past(i_pwdata[13:11], 2)}) + 4'h1) else $error("phase two length");
  chk_tick_gap: assert property (o_tq_tick && seen_q && !cfg |->
    gap_q == {1'b0, presc_q, 1'b0} + 8'h02) else $error("quantum length");
  chk_cfg_quiet: assert property (cfg && $past(cfg) |-> !o_tq_tick)
    else $error("tick in config");
  chk_drop_write: assert property (twr && !cfg |-> ##1 $stable({o_prop_quanta,
    o_jump_quanta, o_phase_one_quanta, o_phase_two_quanta}) [*2]) else $error("write kept");
  chk_triple_gate: assert property (o_triple_sample |-> $past(presc_q) >= 6'h02)
    else $error("triple too fast");
  chk_apb_wait: assert property (s_access |-> !o_pready ##1 o_pready)
    else $error("wait state");
endmodule
bind can_bit_timing_config can_bit_timing_monitor can_bit_timing_monitor_i (.*);
`default_nettype wire

/* File: verif/can_node_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Listening node on the bus side
// ****
module can_node_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_tq_tick,
  input  wire logic       i_bit_start,
  input  wire logic       i_sample_point,
  output logic [7:0]      o_bit_quanta,
  output logic [7:0]      o_tick_gap,
  output logic [7:0]      o_sample_quanta
);
  logic [7:0] qcnt_q;
  logic [7:0] gcnt_q;
  // A node only sees quanta, so it measures bit length in ticks
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      qcnt_q       <= 8'h00;
      o_bit_quanta <= 8'h00;
    end else if (i_bit_start) begin
      qcnt_q       <= 8'h00;
      o_bit_quanta <= qcnt_q + {7'h00, i_tq_tick}; // Tick ending phase two closes this bit
    end else if (i_tq_tick) begin
      qcnt_q <= qcnt_q + 8'h01;
    end
  end
  // Quanta from bit start up to and including the sample point
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_sample_quanta <= 8'h00;
    end else if (i_sample_point) begin
      o_sample_quanta <= qcnt_q + {7'h00, i_tq_tick};
    end
  end
  // Clock cycles between two ticks
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || i_tq_tick) begin
      gcnt_q <= 8'h01;
    end else begin
      gcnt_q <= gcnt_q + 8'h01;
    end
    if (i_rst_b && i_tq_tick) begin
      o_tick_gap <= gcnt_q;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Testbench
// ****
module tb;
  logic i_clk_sys = 1'b0, i_rst_b, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic o_tq_tick, o_bit_start, o_sample_point, o_triple_sample;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdat, v;
  logic [3:0]  o_prop_quanta, o_phase_one_quanta, o_phase_two_quanta;
  logic [2:0]  o_jump_quanta;
  logic [4:0]  o_quanta_per_bit;
  logic [7:0]  bit_q, gap_q, samp_q;
  logic [5:0]  p;
  logic        rerr;
  int          n_errors, n_checks, cyc, k;
  can_bit_timing_config can_bit_timing_config_i (.*);
  can_node_model can_node_model_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_tq_tick(o_tq_tick), .i_bit_start(o_bit_start), .i_sample_point(o_sample_point),
    .o_bit_quanta(bit_q), .o_tick_gap(gap_q), .o_sample_quanta(samp_q));
  always #2 i_clk_sys = ~i_clk_sys;
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n == 16) n_errors++;
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  function automatic logic [31:0] tv(logic [2:0] p2, logic tr, fr,
    logic [2:0] p1, pr, logic [1:0] j, logic [5:0] ps);
    return {13'h0000, p2, tr, fr, p1, pr, j, ps};
  endfunction
  // Hang guard
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {i_rst_b, i_psel, i_penable, i_pwrite} = 4'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h00000000;
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    xfer(0, 12'h000, 0); chk("timing", 32'h00000000, rdat);
    xfer(0, 12'h004, 0); chk("mode", 32'h00800000, rdat);
    xfer(0, 12'h008, 0); chk("status", 32'h00001804, rdat);
    xfer(0, 12'h00C, 0); chk("unmapped", 32'h1, rerr);
    for (k = 0; k < 8; k++) begin
      v = tv(3'h0, 0, 0, 3'h7, k[2:0], k[1:0], 6'h02);
      xfer(1, 12'h000, v);
      xfer(0, 12'h000, 0); chk("timing", v, rdat);
      chk("prop", k + 1, o_prop_quanta);
      chk("jump", k % 4 + 1, o_jump_quanta);
      chk("ph2", 8, o_phase_two_quanta);
      chk("ph1", 8, o_phase_one_quanta);
      chk("qpb", k + 18, o_quanta_per_bit);
    end
    xfer(1, 12'h000, tv(3'h2, 1, 1, 3'h7, 3'h0, 2'h3, 6'h01));
    xfer(0, 12'h008, 0); chk("status", 32'h0000150D, rdat);
    chk("ph2", 3, o_phase_two_quanta);
    chk("triple", 0, o_triple_sample);
    xfer(1, 12'h000, tv(3'h2, 1, 1, 3'h7, 3'h0, 2'h0, 6'h02));
    xfer(0, 12'h000, 0); chk("triple", 1, o_triple_sample);
    xfer(1, 12'h000, tv(3'h7, 0, 1, 3'h0, 3'h0, 2'h0, 6'h02));
    xfer(0, 12'h008, 0); chk("status", 32'h0000120B, rdat);
    for (k = 0; k < 2; k++) begin
      p = k ? 6'h3F : 6'h00;
      v = tv(3'h0, 0, 0, 3'h3, 3'h0, 2'h0, p);
      xfer(1, 12'h004, 32'h00800000);
      xfer(1, 12'h000, v);
      xfer(1, 12'h004, 32'h00000000);
      repeat (3) @(posedge o_bit_start);
      chk("bit", 10, bit_q);
      chk("sample", 6, samp_q);
      chk("gap", 2 * (p + 1), gap_q);
      xfer(1, 12'h000, 32'h0007FFFF); chk("err", 0, rerr);
      xfer(0, 12'h000, 0); chk("kept", v, rdat);
    end
    complete_run();
  end
endmodule
`default_nettype wire
